// ==== logic/esm_defines.svh ====
`ifndef ESM_DEFINES_SVH
`define ESM_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define ESM_CLK_HZ 250000000
`define ESM_ONE_SEC_S 1
`define ESM_ONE_SEC_CYC (`ESM_ONE_SEC_S * `ESM_CLK_HZ)
`define ESM_BAUD 91600
`define ESM_BAUD_CYC (`ESM_CLK_HZ / `ESM_BAUD)
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define ESM_REG_CTRL 8'h00
`define ESM_REG_STATUS 8'h04
`define ESM_REG_RATE 8'h08
`define ESM_REG_CNT_BASE 8'h40
`define ESM_REG_CNT_END 8'h68
`define ESM_CTRL_EN_BIT 0
`define ESM_CTRL_QL_LSB 4
`define ESM_CTRL_CLR_BIT 8
`define ESM_CTRL_EN_RST 1'b1
`define ESM_LOCAL_QL_RST 4'hb
`define ESM_RATE_CAP_RST 8'h0a
`define ESM_RESP_OKAY 2'b00
`define ESM_RESP_SLVERR 2'b10
// ----------------------------------------
// Quality levels and frame layout
// ----------------------------------------
`define ESM_QL_PRC 4'h2
`define ESM_QL_SSUA 4'h4
`define ESM_QL_SSUB 4'h8
`define ESM_QL_SEC 4'hb
`define ESM_QL_DNU 4'hf
`define ESM_TYPE_DNU_INFO 4'h8
`define ESM_MSG_TYPES 10
`define ESM_CNT_W 16
`define ESM_FRAME_WORDS 8
`define ESM_LAST_BYTES 3'h2
`define ESM_RX_DEPTH 8
`define ESM_DA 48'h0180c2000002
`define ESM_ETYPE 16'h8809
`define ESM_SUBTYPE 8'h0a
`define ESM_OUI 24'h0019a7
`define ESM_ITU_SUB 16'h0001
`define ESM_VERSION 4'h1
`define ESM_TLV_TYPE 8'h01
`define ESM_TLV_LEN 16'h0004
`define ESM_RX_EVT_WORD 2
`define ESM_RX_EVT_BIT 27
`define ESM_RX_QL_WORD 3
`define ESM_RX_QL_LSB 32
`endif

// ==== logic/esm_pkg.sv ====
`include "esm_defines.svh"
package esm_pkg;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} esm_axi_req_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} esm_axi_rsp_type;
	typedef struct packed {
		logic valid;
		logic [63:0] data;
		logic sop;
		logic eop;
	} esm_rx_type;
	typedef struct packed {
		logic valid;
		logic [63:0] data;
		logic sop;
		logic eop;
		logic [2:0] last_bytes;
	} esm_tx_type;
	typedef enum logic [2:0] {G_IDLE = 3'b001, G_FRAME = 3'b010, G_WAIT = 3'b100} esm_gen_type;
	typedef enum logic [2:0] {X_IDLE = 3'b001, X_DECODE = 3'b010, X_DONE = 3'b100} esm_ext_type;
	typedef enum logic [1:0] {R_IDLE = 2'b01, R_SEND = 2'b10} esm_rd_type;
	typedef struct packed {
		logic [1:0] init_sync;
		esm_axi_rsp_type axi;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic msg_on;
		logic [3:0] local_ql;
		logic [7:0] rate_cap;
		logic [`ESM_MSG_TYPES-1:0][`ESM_CNT_W-1:0] cnt;
		logic [27:0] sec_cnt;
		logic [7:0] win_cnt;
		logic [11:0] baud_cnt;
		logic uart_tick;
		logic slow;
		logic [`ESM_RX_DEPTH-1:0][63:0] rx_mem;
		logic [3:0] rx_wr;
		logic rx_match;
		logic rx_full;
		esm_ext_type ext;
		logic [3:0] dec_ql;
		logic dec_evt;
		logic [3:0] rx_ql;
		logic seen_ql;
		logic switch_req;
		logic switch_once;
		logic req_pend;
		logic [3:0] req_type;
		logic ack;
		esm_gen_type gen;
		logic [2:0] gen_idx;
		logic [3:0] gen_type;
		logic [`ESM_MSG_TYPES*`ESM_FRAME_WORDS-1:0][63:0] tx_mem;
		logic [`ESM_MSG_TYPES-1:0] slot_full;
		esm_rd_type rd;
		logic [3:0] rd_slot;
		logic [2:0] rd_idx;
		esm_tx_type tx;
	} esm_state_type;
endpackage

// ==== logic/esm_message_top.sv ====
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "esm_defines.svh"
module esm_message_top #(
	parameter int unsigned ONE_SEC_CYC = `ESM_ONE_SEC_CYC,
	parameter int unsigned BAUD_CYC = `ESM_BAUD_CYC,
	parameter logic [47:0] SRC_ADDR = 48'h020000000001
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic power_init_done,
	// Register bus
	input esm_pkg::esm_axi_req_type axi_req,
	output esm_pkg::esm_axi_rsp_type axi_rsp,
	// MAC receive stream
	input esm_pkg::esm_rx_type rx_in,
	// MAC transmit stream
	input wire logic mac_tx_almost_full,
	output esm_pkg::esm_tx_type tx_out,
	// Status
	output logic pll_switch_req,
	output logic msg_sent,
	output logic uart_baud_tick
);
	import esm_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic esm_state_type rst_state();
		esm_state_type s;
		s = '0;
		s.gen = G_IDLE;
		s.ext = X_IDLE;
		s.rd = R_IDLE;
		s.msg_on = `ESM_CTRL_EN_RST;
		s.local_ql = `ESM_LOCAL_QL_RST;
		s.rate_cap = `ESM_RATE_CAP_RST;
		s.switch_req = 1'b1;
		return s;
	endfunction

	localparam esm_state_type RST_S = rst_state();

	function automatic logic [3:0] ql_type(input logic [3:0] ql, input logic evt);
		logic [2:0] idx;
		case (ql)
			`ESM_QL_PRC: idx = 3'h0;
			`ESM_QL_SSUA: idx = 3'h1;
			`ESM_QL_SSUB: idx = 3'h2;
			`ESM_QL_SEC: idx = 3'h3;
			default: idx = 3'h4;
		endcase
		return {idx, evt};
	endfunction

	// Message content: info/event flag and QL follow the type
	function automatic logic [63:0] frame_word(input logic [3:0] t, input logic [2:0] i);
		logic [511:0] f;
		logic [3:0] q;
		case (t[3:1])
			3'h0: q = `ESM_QL_PRC;
			3'h1: q = `ESM_QL_SSUA;
			3'h2: q = `ESM_QL_SSUB;
			3'h3: q = `ESM_QL_SEC;
			default: q = `ESM_QL_DNU;
		endcase
		f = '0;
		f[511:288] = {`ESM_DA, SRC_ADDR, `ESM_ETYPE, `ESM_SUBTYPE, `ESM_OUI,
			`ESM_ITU_SUB, `ESM_VERSION, t[0], 3'h0, 24'h000000, `ESM_TLV_TYPE,
			`ESM_TLV_LEN, 4'h0, q};
		return f[511 - 64 * i -: 64];
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	esm_state_type s_q;
	esm_state_type s_d;

	always_comb begin
		logic new_req;
		logic [3:0] new_type;
		logic [3:0] sel;
		logic [7:0] off;
		logic [6:0] wa;
		logic found;
		new_req = 1'b0;
		new_type = `ESM_TYPE_DNU_INFO;
		sel = '0;
		off = '0;
		wa = '0;
		found = 1'b0;
		s_d = s_q;
		s_d.init_sync = {s_q.init_sync[0], power_init_done};
		s_d.ack = 1'b0;
		s_d.uart_tick = 1'b0;
		s_d.tx.valid = 1'b0;
		s_d.tx.sop = 1'b0;
		s_d.tx.eop = 1'b0;
		s_d.slow = ~s_q.slow;

		// ----------------------------------------
		// Register bus
		// ----------------------------------------
		if (s_q.axi.bvalid && axi_req.bready) begin
			s_d.axi.bvalid = 1'b0;
		end
		if (s_q.axi.rvalid && axi_req.rready) begin
			s_d.axi.rvalid = 1'b0;
		end
		if (s_q.axi.awready && axi_req.awvalid) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = axi_req.awaddr;
		end
		if (s_q.axi.wready && axi_req.wvalid) begin
			s_d.w_have = 1'b1;
			s_d.w_data = axi_req.wdata;
			s_d.w_strb = axi_req.wstrb;
		end
		if (s_d.aw_have && s_d.w_have && !s_q.axi.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.axi.bvalid = 1'b1;
			s_d.axi.bresp = `ESM_RESP_OKAY;
			if (s_d.aw_addr == `ESM_REG_CTRL) begin
				if (s_d.w_strb[0]) begin
					s_d.msg_on = s_d.w_data[`ESM_CTRL_EN_BIT];
					s_d.local_ql = s_d.w_data[`ESM_CTRL_QL_LSB +: 4];
				end
				if (s_d.w_strb[1] && s_d.w_data[`ESM_CTRL_CLR_BIT]) begin
					s_d.cnt = '0;
				end
			end else if (s_d.aw_addr == `ESM_REG_RATE) begin
				if (s_d.w_strb[0]) begin
					s_d.rate_cap = s_d.w_data[7:0];
				end
			end else if (s_d.aw_addr != `ESM_REG_STATUS) begin
				s_d.axi.bresp = `ESM_RESP_SLVERR;
			end
		end
		if (s_q.axi.arready && axi_req.arvalid) begin
			s_d.axi.rvalid = 1'b1;
			s_d.axi.rresp = `ESM_RESP_OKAY;
			s_d.axi.rdata = '0;
			off = axi_req.araddr - `ESM_REG_CNT_BASE;
			if (axi_req.araddr == `ESM_REG_CTRL) begin
				s_d.axi.rdata[`ESM_CTRL_EN_BIT] = s_q.msg_on;
				s_d.axi.rdata[`ESM_CTRL_QL_LSB +: 4] = s_q.local_ql;
			end else if (axi_req.araddr == `ESM_REG_STATUS) begin
				s_d.axi.rdata = {s_q.win_cnt, 8'h00, s_q.rx_ql, s_q.local_ql,
					3'h0, s_q.seen_ql, s_q.req_pend, s_q.rx_full, s_q.switch_req,
					s_q.msg_on};
			end else if (axi_req.araddr == `ESM_REG_RATE) begin
				s_d.axi.rdata[7:0] = s_q.rate_cap;
			end else if (axi_req.araddr >= `ESM_REG_CNT_BASE
					&& axi_req.araddr < `ESM_REG_CNT_END && off[1:0] == 2'h0) begin
				s_d.axi.rdata[`ESM_CNT_W-1:0] = s_q.cnt[off[5:2]];
			end else begin
				s_d.axi.rresp = `ESM_RESP_SLVERR;
			end
		end

		// ----------------------------------------
		// Timers
		// ----------------------------------------
		// Serial rate comes from this clock, as no slower reference is present;
		// the tick period is the whole number of cycles, rounded down
		if (s_q.baud_cnt == 12'(BAUD_CYC - 1)) begin
			s_d.baud_cnt = '0;
			s_d.uart_tick = 1'b1;
		end else begin
			s_d.baud_cnt = s_q.baud_cnt + 12'h001;
		end
		if (s_q.sec_cnt == 28'(ONE_SEC_CYC - 1)) begin
			s_d.sec_cnt = '0;
			s_d.win_cnt = '0;
		end else begin
			s_d.sec_cnt = s_q.sec_cnt + 28'h0000001;
		end

		// ----------------------------------------
		// Receive parser and extraction
		// ----------------------------------------
		// A frame that starts while one is still undecoded is dropped whole,
		// so the decoder never reads a buffer that is being overwritten
		if (rx_in.valid) begin
			if (rx_in.sop) begin
				s_d.rx_match = (rx_in.data[63:16] == `ESM_DA) && !s_q.rx_full;
				s_d.rx_wr = 4'h0;
			end
			if (s_d.rx_match && s_d.rx_wr < 4'(`ESM_RX_DEPTH)) begin
				s_d.rx_mem[s_d.rx_wr[2:0]] = rx_in.data;
				s_d.rx_wr = s_d.rx_wr + 4'h1;
			end
			if (rx_in.eop && s_d.rx_match) begin
				s_d.rx_full = 1'b1;
				s_d.rx_match = 1'b0;
			end
		end
		case (s_q.ext)
			X_IDLE: begin
				if (s_q.rx_full) begin
					s_d.ext = X_DECODE;
				end
			end
			X_DECODE: begin
				s_d.dec_evt = s_q.rx_mem[`ESM_RX_EVT_WORD][`ESM_RX_EVT_BIT];
				s_d.dec_ql = s_q.rx_mem[`ESM_RX_QL_WORD][`ESM_RX_QL_LSB +: 4];
				s_d.rx_full = 1'b0;
				s_d.ext = X_DONE;
			end
			X_DONE: begin
				s_d.ext = X_IDLE;
				new_req = 1'b1;
				if (s_q.msg_on) begin
					sel = (s_q.dec_ql < s_q.local_ql) ? s_q.dec_ql : s_q.local_ql;
					new_type = ql_type(sel, !s_q.seen_ql || s_q.dec_ql != s_q.rx_ql);
					s_d.rx_ql = s_q.dec_ql;
					s_d.seen_ql = 1'b1;
					if (!s_q.switch_once) begin
						s_d.switch_req = 1'b0;
						s_d.switch_once = 1'b1;
					end else if (s_q.dec_ql != s_q.rx_ql) begin
						s_d.switch_req = s_q.dec_ql < s_q.local_ql;
					end
				end else begin
					new_type = `ESM_TYPE_DNU_INFO;
				end
			end
			default: s_d.ext = X_IDLE;
		endcase

		// ----------------------------------------
		// Request servicing and rate cap
		// ----------------------------------------
		// A request arriving while one is pending is dropped
		if (new_req && !s_q.req_pend && s_d.win_cnt < s_q.rate_cap) begin
			s_d.req_pend = 1'b1;
			s_d.req_type = new_type;
			s_d.win_cnt = s_d.win_cnt + 8'h01;
		end

		// ----------------------------------------
		// Generator, on the half-rate enable
		// ----------------------------------------
		// Framing at half rate stands in for the slower generator clock; a slot
		// is marked full only after its last word, so the reader never sees a
		// half-written frame
		if (s_q.slow) begin
			case (s_q.gen)
				G_IDLE: begin
					if (s_q.req_pend && !s_q.slot_full[s_q.req_type]) begin
						s_d.gen_type = s_q.req_type;
						s_d.gen_idx = 3'h0;
						s_d.gen = G_FRAME;
					end
				end
				G_FRAME: begin
					wa = {s_q.gen_type, s_q.gen_idx};
					s_d.tx_mem[wa] = frame_word(s_q.gen_type, s_q.gen_idx);
					s_d.gen_idx = s_q.gen_idx + 3'h1;
					if (s_q.gen_idx == 3'(`ESM_FRAME_WORDS - 1)) begin
						s_d.slot_full[s_q.gen_type] = 1'b1;
						s_d.req_pend = 1'b0;
						s_d.gen = G_WAIT;
					end
				end
				G_WAIT: begin
					if (!s_q.req_pend) begin
						s_d.gen = G_IDLE;
					end else if (!s_q.slot_full[s_q.req_type]) begin
						s_d.gen_type = s_q.req_type;
						s_d.gen_idx = 3'h0;
						s_d.gen = G_FRAME;
					end
				end
				default: s_d.gen = G_IDLE;
			endcase
		end

		// ----------------------------------------
		// Slot reader toward the MAC
		// ----------------------------------------
		// Almost-full freezes the word index, so a stalled frame resumes where
		// it stopped instead of starting again
		case (s_q.rd)
			R_IDLE: begin
				if (!mac_tx_almost_full) begin
					for (int k = `ESM_MSG_TYPES - 1; k >= 0; k--) begin
						if (s_q.slot_full[k]) begin
							found = 1'b1;
							s_d.rd_slot = 4'(k);
						end
					end
					if (found) begin
						s_d.rd_idx = 3'h0;
						s_d.rd = R_SEND;
					end
				end
			end
			R_SEND: begin
				if (!mac_tx_almost_full) begin
					s_d.tx.valid = 1'b1;
					s_d.tx.data = s_q.tx_mem[{s_q.rd_slot, s_q.rd_idx}];
					s_d.tx.sop = (s_q.rd_idx == 3'h0);
					s_d.tx.eop = (s_q.rd_idx == 3'(`ESM_FRAME_WORDS - 1));
					s_d.tx.last_bytes = `ESM_LAST_BYTES;
					s_d.rd_idx = s_q.rd_idx + 3'h1;
					if (s_d.tx.eop) begin
						// Free the slot; the generator never writes a full slot
						s_d.slot_full[s_q.rd_slot] = 1'b0;
						s_d.ack = 1'b1;
						if (s_d.cnt[s_q.rd_slot] != '1) begin
							s_d.cnt[s_q.rd_slot] = s_d.cnt[s_q.rd_slot] + 16'h0001;
						end
						s_d.rd = R_IDLE;
					end
				end
			end
			default: s_d.rd = R_IDLE;
		endcase

		s_d.axi.awready = !s_d.aw_have;
		s_d.axi.wready = !s_d.w_have;
		s_d.axi.arready = !s_d.axi.rvalid;

		// Everything but the init synchroniser waits for init done
		if (!s_q.init_sync[1]) begin
			s_d = RST_S;
			s_d.init_sync = {s_q.init_sync[0], power_init_done};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= RST_S;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign axi_rsp = s_q.axi;
	assign tx_out = s_q.tx;
	assign pll_switch_req = s_q.switch_req;
	assign msg_sent = s_q.ack;
	assign uart_baud_tick = s_q.uart_tick;
endmodule

// ==== sim/esm_message_sva.sv ====
`timescale 1ns/100ps
module esm_message_sva #(
	parameter int unsigned BAUD_CYC = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic power_init_done,
	// Watched ports
	input esm_pkg::esm_axi_req_type axi_req,
	input esm_pkg::esm_axi_rsp_type axi_rsp,
	input wire logic mac_tx_almost_full,
	input esm_pkg::esm_tx_type tx_out,
	input wire logic pll_switch_req,
	input wire logic msg_sent,
	input wire logic uart_baud_tick
);
	import esm_pkg::*;
	// --------
	// Helpers
	// --------
	logic [3:0] wc_q;
	logic [11:0] bc_q;
	logic seen_q;
	// First tick has no reference point, so period checks start after it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wc_q <= 4'h0;
			bc_q <= 12'h000;
			seen_q <= 1'b0;
		end else begin
			if (tx_out.valid) begin
				wc_q <= tx_out.sop ? 4'h1 : wc_q + 4'h1;
			end
			bc_q <= uart_baud_tick ? 12'h000 : bc_q + 12'h001;
			if (uart_baud_tick) begin
				seen_q <= 1'b1;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_SWITCH_RST: assert property ($fell(rst) |-> pll_switch_req [*3])
		else $error("switch request not high after reset");
	AST_FRAME_LEN: assert property (tx_out.valid && tx_out.eop |->
		wc_q == 4'h7 && tx_out.last_bytes == 3'h2)
		else $error("frame length wrong");
	AST_ACK: assert property (msg_sent == (tx_out.valid && tx_out.eop))
		else $error("sent pulse not on last word");
	AST_STALL: assert property (mac_tx_almost_full |=> !tx_out.valid)
		else $error("word sent while almost full");
	AST_WORD_STEP: assert property (tx_out.valid && !tx_out.eop &&
		!mac_tx_almost_full |=> tx_out.valid && !tx_out.sop)
		else $error("frame word did not advance");
	AST_BAUD: assert property (uart_baud_tick && seen_q |-> bc_q == 12'(BAUD_CYC - 1))
		else $error("baud tick period wrong");
	AST_WRESP: assert property (axi_req.awvalid && axi_rsp.awready &&
		axi_req.wvalid && axi_rsp.wready |=> axi_rsp.bvalid)
		else $error("write response late");
	AST_RRESP: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read response late");
	AST_INIT: assert property (!power_init_done [*4] |=>
		!axi_rsp.awready && !axi_rsp.arready)
		else $error("bus live before init done");
	cover property (msg_sent);
	cover property ($rose(pll_switch_req));
	cover property (axi_rsp.rvalid && axi_rsp.rresp == 2'b10);
endmodule
bind esm_message_top esm_message_sva #(.BAUD_CYC(BAUD_CYC)) esm_message_sva_i (.clk(clk),
	.rst(rst), .power_init_done(power_init_done), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.mac_tx_almost_full(mac_tx_almost_full), .tx_out(tx_out),
	.pll_switch_req(pll_switch_req), .msg_sent(msg_sent), .uart_baud_tick(uart_baud_tick));

// ==== sim/esm_mac_model.sv ====
`timescale 1ns/100ps
module esm_mac_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Receive stream toward the block
	output esm_pkg::esm_rx_type rx_out,
	// Transmit stream from the block
	output logic almost_full,
	input esm_pkg::esm_tx_type tx_in
);
	import esm_pkg::*;
	int tx_words;
	logic [47:0] da_q;
	logic [2:0] cyc_q;
	initial begin
		rx_out = '0;
	end
	// Back-pressure two cycles in eight keeps the stall path busy
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cyc_q <= 3'h0;
			almost_full <= 1'b0;
			tx_words <= 0;
			da_q <= '0;
		end else begin
			cyc_q <= cyc_q + 3'h1;
			almost_full <= cyc_q[2:1] == 2'h3;
			if (tx_in.valid) begin
				tx_words <= tx_words + 1;
			end
			if (tx_in.valid && tx_in.sop) begin
				da_q <= tx_in.data[63:16];
			end
		end
	end
	task automatic send(input logic [3:0] ql, input logic [47:0] da = 48'h0180c2000002);
		logic [63:0] w [8];
		w = '{{da, 16'h0200}, {32'h1, 16'h8809, 16'h0a00},
			{16'h19a7, 16'h0001, 8'h10, 24'h0}, {8'h01, 16'h0004, 4'h0, ql, 32'h0},
			64'h0, 64'h0, 64'h0, 64'h0};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rx_out <= '{1'b1, w[i], i == 0, i == 7};
		end
		// Idle data is inverted so a stale word never looks valid
		@(posedge clk);
		rx_out <= '{1'b0, ~w[7], 1'b0, 1'b0};
	endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
	import esm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic init_done = 1'b0;
	esm_axi_req_type req = '0;
	esm_axi_rsp_type rsp;
	esm_rx_type rx;
	esm_tx_type tx;
	logic af, sw, sent, tick;
	int fail_count = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [31:0] d;
	logic [1:0] r;
	always #2 clk = ~clk;
	esm_message_top #(.ONE_SEC_CYC(2000), .BAUD_CYC(10)) esm_message_top_i (.clk(clk),
		.rst(rst), .power_init_done(init_done), .axi_req(req), .axi_rsp(rsp), .rx_in(rx),
		.mac_tx_almost_full(af), .tx_out(tx), .pll_switch_req(sw), .msg_sent(sent),
		.uart_baud_tick(tick));
	esm_mac_model esm_mac_model_i (.clk(clk), .rst(rst), .rx_out(rx), .almost_full(af),
		.tx_in(tx));
	// --------
	// Helpers
	// --------
	task end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= wd;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] rd_d, output logic [1:0] rd_r);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rd_d = rsp.rdata;
		rd_r = rsp.rresp;
		req.rready <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a, d, r);
		check(d, e);
		check({30'h0, r}, {30'h0, er});
	endtask
	task wait_sent(output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			@(posedge clk);
			ok = sent === 1'b1;
		end
	endtask
	// --------
	// Scenarios
	// --------
	task t_reset();
		check({31'h0, sw}, 32'h1);
		rdchk(8'h00, 32'h000000b1, 2'b00);
		rdchk(8'h04, 32'h00000b03, 2'b00);
		rdchk(8'h08, 32'h0000000a, 2'b00);
		rdchk(8'h80, 32'h0, 2'b10);
		wr(8'h80, 32'h000000ff);
		check({30'h0, r}, 32'h2);
		wr(8'h04, 32'hffffffff);
		check({30'h0, r}, 32'h0);
		rdchk(8'h04, 32'h00000b03, 2'b00);
		$display("reset test done");
	endtask
	task t_frames();
		logic ok;
		esm_mac_model_i.send(`ESM_QL_SEC);
		wait_sent(ok);
		check({31'h0, ok}, 32'h1);
		check({31'h0, sw}, 32'h0);
		check(esm_mac_model_i.da_q[31:0], 32'hc2000002);
		esm_mac_model_i.send(`ESM_QL_PRC);
		wait_sent(ok);
		check({31'h0, ok}, 32'h1);
		check({31'h0, sw}, 32'h1);
		@(posedge clk);
		check(esm_mac_model_i.tx_words, 32'd16);
		rdchk(8'h5c, 32'h1, 2'b00);
		rdchk(8'h44, 32'h1, 2'b00);
		rd(8'h04, d, r);
		check(d & 32'h0000f000, 32'h00002000);
		$display("frame test done");
	endtask
	task t_disable();
		logic ok;
		wr(8'h00, 32'h000000a0);
		esm_mac_model_i.send(`ESM_QL_SSUA);
		wait_sent(ok);
		check({31'h0, ok}, 32'h1);
		rdchk(8'h60, 32'h1, 2'b00);
		rd(8'h04, d, r);
		check(d & 32'h0000ff01, 32'h00002a00);
		$display("disable test done");
	endtask
	task t_clear();
		logic ok;
		wr(8'h00, 32'h000001b1);
		check({30'h0, r}, 32'h0);
		esm_mac_model_i.send(`ESM_QL_PRC, 48'h0180c2000003);
		wait_sent(ok);
		check({31'h0, ok}, 32'h0);
		for (int t = 0; t < 10; t++) begin
			rdchk(8'h40 + 8'(4 * t), 32'h0, 2'b00);
		end
		$display("clear test done");
	endtask
	task t_cap();
		logic ok;
		wr(8'h08, 32'h0);
		esm_mac_model_i.send(`ESM_QL_PRC);
		wait_sent(ok);
		check({31'h0, ok}, 32'h0);
		rdchk(8'h44, 32'h0, 2'b00);
		$display("cap test done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		init_done <= 1'b1;
		repeat (8) @(posedge clk);
		t_reset();
		t_frames();
		t_disable();
		t_clear();
		t_cap();
		end_of_test();
	end
endmodule
